// >>> rtl/spr_params.svh
// offsets, field positions, reset values and fixed codes of the serial port
`ifndef SPR_PARAMS_SVH
`define SPR_PARAMS_SVH
// register indices; byte address is four times the index
`define SPR_IDX_STATUS  16'h4320
`define SPR_IDX_TX      16'h4322
`define SPR_IDX_RX      16'h4324
`define SPR_IDX_CTRL    16'h4326
`define SPR_IDX_IRQ     16'h4328
// status fields
`define SPR_ST_TXE      0
`define SPR_ST_RXF      1
`define SPR_ST_BSY      2
// control fields
`define SPR_CT_EN       0
`define SPR_CT_MSTR     1
`define SPR_CT_CLOCK_POLARITY_SEL     2
`define SPR_CT_CLOCK_PHASE_SEL     3
`define SPR_CT_TIE      4
`define SPR_CT_RIE      5
`define SPR_CT_W        6
`define SPR_CT_RESET    6'h00
// interrupt controller slot fields
`define SPR_IQ_LVL_LO   0
`define SPR_IQ_LVL_HI   2
`define SPR_IQ_GATE     3
`define SPR_IQ_PEND     4
`define SPR_VEC_NUM     8'h12
`define SPR_VEC_ADDR    16'h8048
// bus code and last serial edge and bit counts
`define SPR_HTRANS_ACT  1
`define SPR_LAST_EDGE   4'hF
`define SPR_LAST_BIT    3'h7
`endif

// >>> rtl/spr_pkg.sv
// types shared by the serial port design
package spr_pkg;
   typedef enum logic [2:0] {SEL_NONE, SEL_STATUS, SEL_TX, SEL_RX, SEL_CTRL, SEL_IRQ}
      spr_regsel_type;
endpackage

// >>> rtl/spr_port.sv
// byte-wide synchronous serial port with AHB-Lite register access
//
// Overview of operation
// - master: each transmit write starts a full-duplex byte exchange
// - master exchange drives serial clock out on the clock pin
// - slave: receive runs on remote clock edges, no write needed
// - bits shift in MSB first on edge chosen by phase and polarity
// - after eighth bit, shift register copies into one-byte receive buffer
// - receive-full rises on buffer load, clears on receive data read
// - newer byte overwrites unread buffer, no error flag
// - master busy bit tracks shift activity during receive too
// - disabling empties both buffers and drops held bytes
// - one shared interrupt request output for both causes
// - buffer-to-shift move sets empty flag, pulses request if enabled
// - receive buffer load pulses request if receive enable set
// - pending flag set by every pulse; forwarded only when gated on
// - 3-bit priority level, vector 18 at address 0x8048
// - five 16-bit registers: status, transmit, receive, control, interrupt slot
// - reserved bits read zero, software writes zero
// - status: empty bit0 reset 1, full bit1, busy bit2
// - slave: status bit2 is 1 while select held low
// - control: enable, master, polarity, phase, two interrupt enables
// - transmit write clears empty flag until byte moves on
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
`include "spr_params.svh"

module spr_port
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // serial pins
   input  wire logic        serialInPin,
   output logic             serialOutPin,
   input  wire logic        serialClockIn,
   output logic             serialClockOut,
   output logic             serialClockOe_n,
   input  wire logic        selectPin_n,
   // bit clock from the external timer channel
   input  wire logic        timerClk,
   // toward the interrupt controller
   output logic             irqPulse,
   output logic             irqToCore,
   output logic [2:0]       irqLevel,
   output logic [7:0]       irqVectorNum,
   output logic [15:0]      irqVectorAddr
);

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   logic [`SPR_CT_W-1:0]   ctrl;
   logic [7:0]             txBuf;
   logic                   txFull;
   logic [7:0]             txShift;
   logic [7:0]             rxShift;
   logic [7:0]             rxBuf;
   logic                   rxFull;
   logic                   busy;
   logic [3:0]             edgeCnt;
   logic                   irqPending;
   logic                   irqGate;
   spr_pkg::spr_regsel_type dSel;
   logic                   dWr;
   logic                   timS1, timS2, timPrev;
   logic                   sckS1, sckS2, sckPrev;
   logic                   selS1, selS2;
   logic                   sdiS1, sdiS2;

   logic                   en, master, clock_polarity_sel, clock_phase_sel;
   logic                   take, rdRx, wrTx, wrCtrl, wrIrq;
   logic                   edgeEv, sampleEv, shiftEv, byteEnd;
   logic                   rxLoad, txLoad, nowBusy;
   spr_pkg::spr_regsel_type aSel;
   logic [15:0]            next_rdata;

   assign en     = ctrl[`SPR_CT_EN];
   assign master = ctrl[`SPR_CT_MSTR];
   assign clock_polarity_sel   = ctrl[`SPR_CT_CLOCK_POLARITY_SEL];
   assign clock_phase_sel   = ctrl[`SPR_CT_CLOCK_PHASE_SEL];

   // ==================================================
   // input synchronisers
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         timS1 <= 1'b0;
         timS2 <= 1'b0;
         timPrev <= 1'b0;
         sckS1 <= 1'b0;
         sckS2 <= 1'b0;
         sckPrev <= 1'b0;
         selS1 <= 1'b1;
         selS2 <= 1'b1;
         sdiS1 <= 1'b0;
         sdiS2 <= 1'b0;
      end
      else
      begin
         timS1 <= timerClk;
         timS2 <= timS1;
         timPrev <= timS2;
         sckS1 <= serialClockIn;
         sckS2 <= sckS1;
         sckPrev <= sckS2;
         selS1 <= selectPin_n;
         selS2 <= selS1;
         sdiS1 <= serialInPin;
         sdiS2 <= sdiS1;
      end
   end

   // ==================================================
   // bus decode
   always_comb
   begin
      aSel = spr_pkg::SEL_NONE;
      if (haddr[31:18] == 14'h0000 && haddr[1:0] == 2'h0)
      begin
         case (haddr[17:2])
            `SPR_IDX_STATUS: aSel = spr_pkg::SEL_STATUS;
            `SPR_IDX_TX:     aSel = spr_pkg::SEL_TX;
            `SPR_IDX_RX:     aSel = spr_pkg::SEL_RX;
            `SPR_IDX_CTRL:   aSel = spr_pkg::SEL_CTRL;
            `SPR_IDX_IRQ:    aSel = spr_pkg::SEL_IRQ;
            default:         aSel = spr_pkg::SEL_NONE;
         endcase
      end
   end

   assign take   = hsel & htrans[`SPR_HTRANS_ACT] & hready;
   assign rdRx   = take & ~hwrite & (aSel == spr_pkg::SEL_RX);
   assign wrTx   = dWr & (dSel == spr_pkg::SEL_TX);
   assign wrCtrl = dWr & (dSel == spr_pkg::SEL_CTRL);
   assign wrIrq  = dWr & (dSel == spr_pkg::SEL_IRQ);

   // read data is fetched at the address phase so the slave never waits
   always_comb
   begin
      next_rdata = 16'h0000;
      case (aSel)
         spr_pkg::SEL_STATUS:
         begin
            next_rdata[`SPR_ST_TXE] = ~txFull;
            next_rdata[`SPR_ST_RXF] = rxFull;
            next_rdata[`SPR_ST_BSY] = master ? busy : ~selS2;
         end
         spr_pkg::SEL_TX:   next_rdata[7:0] = txBuf;
         spr_pkg::SEL_RX:   next_rdata[7:0] = rxBuf;
         spr_pkg::SEL_CTRL: next_rdata[`SPR_CT_W-1:0] = ctrl;
         spr_pkg::SEL_IRQ:
         begin
            next_rdata[`SPR_IQ_LVL_HI:`SPR_IQ_LVL_LO] = irqLevel;
            next_rdata[`SPR_IQ_GATE] = irqGate;
            next_rdata[`SPR_IQ_PEND] = irqPending;
         end
         default:           next_rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         dSel <= spr_pkg::SEL_NONE;
         dWr <= 1'b0;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         dSel <= take ? aSel : spr_pkg::SEL_NONE;
         dWr <= take & hwrite;
         // reserved and unmapped bits read zero
         if (take & ~hwrite)
            hrdata <= {16'h0000, next_rdata};
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ==================================================
   // control register
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         ctrl <= `SPR_CT_RESET;
      // six control bits, reserved bits dropped
      else if (wrCtrl)
         ctrl <= hwdata[`SPR_CT_W-1:0];
   end

   // ==================================================
   // serial timing: edges come from the timer (master) or the pin (slave)
   // slave counts remote edges only
   assign edgeEv   = master ? (en & busy & timS2 & ~timPrev)
                            : (en & ~selS2 & (sckS2 ^ sckPrev));
   // phase chooses sampling on leading or trailing edges
   assign sampleEv = edgeEv & (edgeCnt[0] == clock_phase_sel);
   assign shiftEv  = edgeEv & (edgeCnt[0] != clock_phase_sel) & (edgeCnt != 4'h0);
   assign rxLoad   = sampleEv & (edgeCnt[3:1] == `SPR_LAST_BIT);
   assign byteEnd  = edgeEv & (edgeCnt == `SPR_LAST_EDGE);
   // the slave loads only between bytes; a write mid-byte waits for the next
   assign nowBusy  = master ? busy : (busy | (edgeCnt != 4'h0) | edgeEv);
   // idle master write starts the exchange at once
   assign txLoad   = en & txFull & (~nowBusy | byteEnd);

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         edgeCnt <= 4'h0;
      else if (~en | (~master & selS2))
         edgeCnt <= 4'h0;
      else if (edgeEv)
         edgeCnt <= edgeCnt + 4'h1;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         busy <= 1'b0;
      else if (~en | (~master & selS2))
         busy <= 1'b0;
      // busy spans each byte started by a transmit load, except a slave load made while deselected; receive-only slave bytes leave it clear
      else if (txLoad)
         busy <= 1'b1;
      else if (byteEnd)
         busy <= 1'b0;
   end

   // ==================================================
   // master clock output; idles at the polarity level
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         serialClockOut <= 1'b0;
         serialClockOe_n <= 1'b1;
      end
      else
      begin
         serialClockOe_n <= ~(en & master);
         // toggle once per rising timer edge while exchanging
         if (~busy | ~master)
            serialClockOut <= clock_polarity_sel;
         else if (edgeEv)
            serialClockOut <= ~serialClockOut;
      end
   end

   // ==================================================
   // transmit buffer and shift register
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         txBuf <= 8'h00;
         txFull <= 1'b0;
      end
      else if (~en & ~wrTx)
      begin
         txBuf <= 8'h00;
         txFull <= 1'b0;
      end
      // write marks buffer full; overwrites an unsent byte
      else if (wrTx)
      begin
         txBuf <= hwdata[7:0];
         txFull <= 1'b1;
      end
      // move to shift register empties the buffer
      else if (txLoad)
         txFull <= 1'b0;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         txShift <= 8'hFF;
      else if (~en)
         txShift <= 8'hFF;
      else if (txLoad)
         txShift <= txBuf;
      else if (shiftEv)
         txShift <= {txShift[6:0], 1'b1};
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         serialOutPin <= 1'b1;
      else if (txLoad)
         serialOutPin <= txBuf[7];
      else if (shiftEv)
         serialOutPin <= txShift[6];
   end

   // ==================================================
   // receive shift register and buffer
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         rxShift <= 8'h00;
      else if (~en)
         rxShift <= 8'h00;
      else if (sampleEv)
         rxShift <= {rxShift[6:0], sdiS2};
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         rxBuf <= 8'h00;
         rxFull <= 1'b0;
      end
      else if (~en)
      begin
         rxBuf <= 8'h00;
         rxFull <= 1'b0;
      end
      // newer byte simply overwrites; set wins over read clear
      else if (rxLoad)
      begin
         rxBuf <= {rxShift[6:0], sdiS2};
         rxFull <= 1'b1;
      end
      else if (rdRx)
         rxFull <= 1'b0;
   end

   // ==================================================
   // interrupt request and controller slot
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         irqPulse <= 1'b0;
      // one shared request; one-cycle pulse in the cycle after each cycle with an event
      // each cause gated by its own enable
      else
         irqPulse <= (txLoad & ctrl[`SPR_CT_TIE]) | (rxLoad & ctrl[`SPR_CT_RIE]);
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         irqPending <= 1'b0;
         irqGate <= 1'b0;
         irqLevel <= 3'h0;
      end
      else
      begin
         // pulse sets pending regardless of gate; write 1 clears
         if (irqPulse)
            irqPending <= 1'b1;
         else if (wrIrq & hwdata[`SPR_IQ_PEND])
            irqPending <= 1'b0;
         if (wrIrq)
         begin
            irqGate <= hwdata[`SPR_IQ_GATE];
            irqLevel <= hwdata[`SPR_IQ_LVL_HI:`SPR_IQ_LVL_LO];
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         irqToCore <= 1'b0;
         irqVectorNum <= `SPR_VEC_NUM;
         irqVectorAddr <= `SPR_VEC_ADDR;
      end
      else
      begin
         irqToCore <= irqPending & irqGate;
         irqVectorNum <= `SPR_VEC_NUM;
         irqVectorAddr <= `SPR_VEC_ADDR;
      end
   end

   // ==================================================
   // checks
   sequence masterStart;
      wrTx && master && en && !busy && !txFull;
   endsequence

   sequence byteDone;
      rxLoad ##1 rxFull;
   endsequence

   master_start_a : assert property (masterStart |=> txFull ##1 busy && !txFull)
      else $error("master write did not start exchange");
   sclk_toggle_a : assert property (master && busy && edgeEv
      |=> serialClockOut != $past(serialClockOut))
      else $error("serial clock did not toggle");
   rx_load_a : assert property (rxLoad |-> byteDone)
      else $error("receive buffer not loaded");
   rx_clear_a : assert property (rdRx && !rxLoad && en |=> !rxFull)
      else $error("receive read did not clear full");
   tx_irq_a : assert property (txLoad && ctrl[`SPR_CT_TIE] |=> irqPulse ##1 irqPending)
      else $error("transmit empty request missing");
   rx_irq_a : assert property (rxLoad && !ctrl[`SPR_CT_RIE] && !txLoad |=> !irqPulse)
      else $error("receive request while disabled");
   irq_gate_a : assert property (irqPending && irqGate |=> irqToCore)
      else $error("gated request not forwarded");
   disable_flush_a : assert property ($fell(en) |=> !rxFull && !busy && !txFull)
      else $error("disable left data held");
   tx_write_a : assert property (wrTx && en |=> txFull || busy)
      else $error("transmit write lost");
   bus_okay_a : assert property (hreadyout && !hresp)
      else $error("slave answered wait or error");

endmodule

// >>> test/spr_remote_model.sv
// remote serial device: slave to the port in master mode, master to it in slave mode
`timescale 1ns/1ns

module spr_remote_model
(
   // serial lines seen from the remote side
   input  wire logic sclkLine,
   input  wire logic fromPort,
   output logic      toPort,
   output logic      clkDrive,
   output logic      select_n
);
   logic [15:0] slaveBits;
   logic        asMaster;

   initial
   begin
      slaveBits = 16'hFFFF;
      asMaster = 1'b0;
      toPort = 1'b1;
      clkDrive = 1'b0;
      select_n = 1'b1;
   end

   // changes land a little after the caller's clock edge, never on it
   task arm(input logic [15:0] v);
      #2;
      slaveBits = v;
      toPort = v[15];
   endtask

   // data moves on falling clock edges, ready before the sampling edge
   always @(negedge sclkLine)
   if (!asMaster)
   begin
      slaveBits = {slaveBits[14:0], ~slaveBits[15]};
      toPort = slaveBits[15];
   end

   task select(input logic v);
      #2;
      asMaster = ~v;
      select_n = v;
   endtask

   // clock only runs inside a frame; once released the data line flips
   task clock_byte(input logic [7:0] txv, output logic [7:0] rxv);
      #3;
      for (int i = 7; i >= 0; i--)
      begin
         toPort = txv[i];
         #80 clkDrive = 1'b1;
         rxv[i] = fromPort;
         #80 clkDrive = 1'b0;
      end
      toPort = ~txv[0];
   endtask
endmodule

// >>> test/tb_spr_port.sv
// register-level bench of the serial port against a remote device model
`timescale 1ns/1ns

module tb_spr_port;
   localparam logic [31:0] A_ST = 32'h00010C80;
   localparam logic [31:0] A_TX = 32'h00010C88;
   localparam logic [31:0] A_RX = 32'h00010C90;
   localparam logic [31:0] A_CT = 32'h00010C98;
   localparam logic [31:0] A_IQ = 32'h00010CA0;

   logic        ref_clk;
   logic        rst;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [2:0]  hsize;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   logic        serialOutPin;
   logic        serialClockOut;
   logic        serialClockOe_n;
   logic        timerClk;
   logic        irqPulse;
   logic        irqToCore;
   logic [2:0]  irqLevel;
   logic [7:0]  irqVectorNum;
   logic [15:0] irqVectorAddr;
   logic        remData;
   logic        remClk;
   logic        remSel_n;
   wire         sclkWire;
   int          badCount;
   int          nCompared;
   int          irqCount;
   int          toggles;
   logic        wideIrq;
   logic        lastIrq;
   logic [7:0]  outCap;
   logic [7:0]  remRx;
   logic [31:0] d;

   // the clock pin is shared: the port drives it only while its enable is low
   assign sclkWire = serialClockOe_n ? remClk : serialClockOut;

   spr_port uut
   (
      .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serialInPin(remData),
      .serialOutPin(serialOutPin), .serialClockIn(sclkWire),
      .serialClockOut(serialClockOut), .serialClockOe_n(serialClockOe_n),
      .selectPin_n(remSel_n), .timerClk(timerClk), .irqPulse(irqPulse),
      .irqToCore(irqToCore), .irqLevel(irqLevel), .irqVectorNum(irqVectorNum),
      .irqVectorAddr(irqVectorAddr)
   );

   spr_remote_model rem
   (
      .sclkLine(sclkWire), .fromPort(serialOutPin), .toPort(remData),
      .clkDrive(remClk), .select_n(remSel_n)
   );

   // ==============================================================
   // clocks, monitors and watchdog
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   initial
   begin
      timerClk = 1'b0;
      forever #80 timerClk = ~timerClk;
   end

   always @(posedge ref_clk)
   begin
      if (irqPulse === 1'b1) irqCount++;
      if (irqPulse === 1'b1 && lastIrq === 1'b1) wideIrq = 1'b1;
      lastIrq = irqPulse;
   end

   always @(posedge sclkWire) outCap = {outCap[6:0], serialOutPin};
   always @(sclkWire) toggles++;

   initial
   begin
      #200000;
      badCount++;
      tallyAndFinish();
   end

   // ==============================================================
   // checking and bus tasks
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp)
      begin
         badCount++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task tallyAndFinish;
      $display("compared %0d, mismatches %0d", nCompared, badCount);
      if (badCount == 0 && nCompared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // address phase held until hready, then data phase until hready again
   task bus(input logic wr, input logic [31:0] a, input logic [31:0] wv);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      hsize <= 3'b010;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wv;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      d = hrdata;
   endtask

   task rd(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(d, exp);
   endtask

   task wait_idle;
      int n;
      n = 0;
      d = 32'h4;
      while (d[2] === 1'b1 && n < 400)
      begin
         bus(1'b0, A_ST, 32'h0);
         n++;
      end
      if (n == 400) chk(d, 32'h0);
   endtask

   task clear_counts;
      irqCount = 0;
      toggles = 0;
      wideIrq = 1'b0;
   endtask

   // ==============================================================
   // test sequence
   initial
   begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      hsize = 3'b010;
      badCount = 0;
      nCompared = 0;
      lastIrq = 1'b0;
      clear_counts();
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      rd(A_ST, 32'h0001); // status after reset
      rd(A_CT, 32'h0000); // control after reset
      rd(A_RX, 32'h0000); // receive buffer after reset
      rd(32'h00010CA4, 32'h0000); // unmapped word reads zero
      chk(irqVectorNum, 32'h12); // vector number
      chk(irqVectorAddr, 32'h8048); // vector address
      chk(hresp, 32'h0); // slave always answers okay
      // single master exchange with both interrupt causes on
      bus(1'b1, A_CT, 32'h0032);
      rd(A_CT, 32'h0032); // control fields read back
      bus(1'b1, A_CT, 32'h0033);
      rem.arm(16'hA500);
      clear_counts();
      bus(1'b1, A_TX, 32'h003C);
      rd(A_ST, 32'h0005); // busy and empty after load
      chk(serialClockOe_n, 32'h0); // port drives the clock pin
      wait_idle();
      rd(A_ST, 32'h0003); // full raised on load
      rd(A_TX, 32'h003C); // transmit byte reads back
      rd(A_RX, 32'h00A5); // received MSB first
      rd(A_ST, 32'h0001); // full cleared by read
      chk(toggles, 32'd16); // sixteen clock edges
      chk(outCap, 32'h3C); // written byte sent
      chk(irqCount, 32'd2); // one pulse per cause
      chk(wideIrq, 32'h0); // pulse lasts one cycle
      // back-to-back bytes, second received byte overwrites the first
      rem.arm(16'h5AC3);
      clear_counts();
      bus(1'b1, A_TX, 32'h003C);
      bus(1'b1, A_TX, 32'h00C6);
      rd(A_ST, 32'h0004); // second write holds buffer
      wait_idle();
      rd(A_ST, 32'h0003); // buffer loaded after eight bits
      chk(toggles, 32'd32); // clock for both bytes
      chk(outCap, 32'hC6); // second byte sent
      chk(irqCount, 32'd4); // pulses for both bytes
      rd(A_RX, 32'h00C3); // newer byte kept
      // pending flag set with gate off, then gated, then cleared
      rd(A_IQ, 32'h0010); // pending set regardless of gate
      chk(irqToCore, 32'h0); // not forwarded while gated off
      bus(1'b1, A_IQ, 32'h000D);
      rd(A_IQ, 32'h001D); // level and gate stored
      chk(irqToCore, 32'h1); // single request to core
      chk(irqLevel, 32'h5); // priority level output
      bus(1'b1, A_IQ, 32'h001D);
      rd(A_IQ, 32'h000D); // pending cleared by write of one
      chk(irqToCore, 32'h0); // request withdrawn
      // polarity and phase both set: data out on leading edges, in on trailing
      rd(A_ST, 32'h0001); // empty and not full before disabling
      bus(1'b1, A_CT, 32'h000E);
      bus(1'b1, A_CT, 32'h000F);
      rd(A_CT, 32'h000F); // polarity and phase read back
      rem.arm(16'h5A00);
      clear_counts();
      bus(1'b1, A_TX, 32'h0081);
      wait_idle();
      chk(toggles, 32'd16); // clock idles high around the byte
      chk(outCap, 32'h81); // byte sent with phase set
      rd(A_RX, 32'h00B4); // sampled on trailing edges
      // interrupts masked, then disable with a byte still held
      bus(1'b1, A_CT, 32'h0002);
      bus(1'b1, A_CT, 32'h0003);
      rem.arm(16'h7E00);
      clear_counts();
      bus(1'b1, A_TX, 32'h0081);
      wait_idle();
      chk(irqCount, 32'd0); // no pulse with enables off
      rd(A_ST, 32'h0003); // empty set even when masked
      bus(1'b1, A_CT, 32'h0002);
      rd(A_ST, 32'h0001); // disable empties buffers
      rd(A_RX, 32'h0000); // held byte dropped
      // slave mode: remote master selects, clocks a byte, deselects
      bus(1'b1, A_CT, 32'h0000);
      bus(1'b1, A_CT, 32'h0001);
      rd(A_ST, 32'h0001); // deselected reads zero
      chk(serialClockOe_n, 32'h1); // slave takes the clock pin as input
      bus(1'b1, A_TX, 32'h0096); // byte loaded before clocking
      rem.select(1'b0);
      repeat (8) @(posedge ref_clk);
      bus(1'b0, A_ST, 32'h0);
      chk(d & 32'h4, 32'h4); // selected reads one
      rem.clock_byte(8'h69, remRx);
      repeat (8) @(posedge ref_clk);
      rem.select(1'b1);
      repeat (8) @(posedge ref_clk);
      chk(remRx, 32'h96); // slave shifts on remote clock
      rd(A_RX, 32'h0069); // byte received from the remote master
      bus(1'b0, A_ST, 32'h0);
      chk(d & 32'h4, 32'h0); // deselect clears bit two
      tallyAndFinish();
   end
endmodule
